// *** src/sml_defines.svh ***
// Purpose: Offsets, field positions, reset values and codes of the supply level registers
// Assumes: 8-bit registers at byte addresses on the register port
// Notes: Definitions only
`ifndef SML_DEFINES_SVH
`define SML_DEFINES_SVH

`define SML_OFS_MON1 8'h14
`define SML_OFS_MON2 8'h15
`define SML_OFS_CONV 8'h16
`define SML_RESET_VAL 8'h00

`define SML_MON1_TOL_HI 4
`define SML_MON1_TOL_LO 3
`define SML_MON1_LVL_HI 2
`define SML_MON1_LVL_LO 0
`define SML_ANA_TOL_HI 7
`define SML_ANA_TOL_LO 6
`define SML_ANA_LVL_BIT 5
`define SML_MON2_TOL_HI 4
`define SML_MON2_TOL_LO 3
`define SML_MON2_LVL_HI 2
`define SML_MON2_LVL_LO 0
`define SML_BOOST_TOL_HI 7
`define SML_BOOST_TOL_LO 6
`define SML_BOOST_LVL_HI 5
`define SML_BOOST_LVL_LO 4
`define SML_STEP1_TOL_HI 3
`define SML_STEP1_TOL_LO 2
`define SML_STEP0_TOL_HI 1
`define SML_STEP0_TOL_LO 0

`define SML_MON_OFF_LEVEL 3'h0

`endif

// *** src/sml_pkg.sv ***
// Purpose: Types shared by the supply level register files
// Assumes: Decoded values are given in percent, millivolts or tens of millivolts
// Notes: None
package sml_pkg;

  typedef enum {
    SML_LOAD_WAIT,
    SML_LOAD_DONE
  } sml_load_state_type;

  typedef logic [7:0] sml_byte_type;

endpackage : sml_pkg

// *** src/sml_monitor_decode.sv ***
// Purpose: Decodes one external monitor input's tolerance and level codes
// Assumes: Codes come from a register on the same clock
// Notes: Purely combinational
`include "sml_defines.svh"

module sml_monitor_decode
  import sml_pkg::*;
(
  input wire logic [1:0] tolerance_code,
  input wire logic [2:0] level_code,
  output logic [3:0] tolerance_pct,
  output logic [11:0] level_mv,
  output logic divider_on
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  always_comb begin
    case (tolerance_code)
      2'h0: tolerance_pct = 4'h2;
      2'h1: tolerance_pct = 4'h3;
      2'h2: tolerance_pct = 4'h4;
      default: tolerance_pct = 4'h6;
    endcase
  end

  always_comb begin
    case (level_code)
      3'h0: level_mv = 12'h28a;
      3'h1: level_mv = 12'h320;
      3'h2: level_mv = 12'h3e8;
      3'h3: level_mv = 12'h44c;
      3'h4: level_mv = 12'h4b0;
      3'h5: level_mv = 12'h514;
      default: level_mv = 12'h708;
    endcase
  end

  // Code zero keeps the pin high impedance for an external divider
  assign divider_on = (level_code != `SML_MON_OFF_LEVEL);

endmodule : sml_monitor_decode

// *** src/sml_otp_loader.sv ***
// Purpose: Sequences the one-time load of defaults after reset
// Assumes: otp_valid is a level from logic on the same clock
// Notes: Issues a single load pulse, then stays done until reset
module sml_otp_loader
  import sml_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic otp_valid,
  output logic load_pulse,
  output logic load_done
);

  sml_load_state_type state_r;
  sml_load_state_type state_nxt;

  always_comb begin
    case (state_r)
      SML_LOAD_WAIT: state_nxt = otp_valid ? SML_LOAD_DONE : SML_LOAD_WAIT;
      SML_LOAD_DONE: state_nxt = SML_LOAD_DONE;
      default: state_nxt = SML_LOAD_WAIT;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= SML_LOAD_WAIT;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign load_pulse = (state_r == SML_LOAD_WAIT) && otp_valid;
  assign load_done = (state_r == SML_LOAD_DONE);

endmodule : sml_otp_loader

// *** src/sml_level_regs.sv ***
// Purpose: Three byte-wide comparison level registers for the power-good supervisors
// Assumes: Register port is byte wide on the device clock; OTP defaults arrive on this clock
// Notes: Decoded selections are registered before they drive the analog comparators
`include "sml_defines.svh"

module sml_level_regs
  import sml_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic otp_valid,
  input wire logic [7:0] otp_mon1_default,
  input wire logic [7:0] otp_mon2_default,
  input wire logic [7:0] otp_conv_default,
  input wire logic two_sided_check_select,
  output logic defaults_loaded,
  output logic [3:0] first_input_tolerance,
  output logic [11:0] first_input_level,
  output logic first_input_divider_on,
  output logic [3:0] second_input_tolerance,
  output logic [11:0] second_input_level,
  output logic second_input_divider_on,
  output logic [3:0] analog_supply_tolerance,
  output logic [11:0] analog_supply_level,
  output logic [3:0] boost_tolerance,
  output logic [1:0] boost_level_code,
  output logic [6:0] first_step_down_tolerance,
  output logic [6:0] second_step_down_tolerance,
  output logic over_check_enable,
  output logic under_check_enable
);

  sml_byte_type mon1_r;
  sml_byte_type mon2_r;
  sml_byte_type conv_r;
  logic load_pulse;
  logic load_done;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [3:0] tol1_w;
  logic [3:0] tol2_w;
  logic [11:0] lvl1_w;
  logic [11:0] lvl2_w;
  logic div1_w;
  logic div2_w;
  logic wr_mon1_w;
  logic wr_mon2_w;
  logic wr_conv_w;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [6:0] step_down_mv(input logic [1:0] code);
    case (code)
      2'h0: step_down_mv = 7'h1e;
      2'h1: step_down_mv = 7'h32;
      2'h2: step_down_mv = 7'h46;
      default: step_down_mv = 7'h5a;
    endcase
  endfunction : step_down_mv

  function automatic logic [3:0] supply_tol_pct(input logic [1:0] code);
    case (code)
      2'h0: supply_tol_pct = 4'h4;
      2'h1: supply_tol_pct = 4'h5;
      default: supply_tol_pct = 4'ha;
    endcase
  endfunction : supply_tol_pct

  function automatic logic [3:0] boost_tol_pct(input logic [1:0] code);
    case (code)
      2'h0: boost_tol_pct = 4'h2;
      2'h1: boost_tol_pct = 4'h4;
      2'h2: boost_tol_pct = 4'h6;
      default: boost_tol_pct = 4'h8;
    endcase
  endfunction : boost_tol_pct

  // Tens of millivolts, so 3.3 V needs no fraction on the comparator bus
  function automatic logic [11:0] supply_level(input logic sel);
    supply_level = sel ? 12'h1f4 : 12'h14a;
  endfunction : supply_level

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
    addr_is = (a == ofs);
  endfunction : addr_is

  // ----------------------------------------
  // Default load sequencing
  // ----------------------------------------
  sml_otp_loader u_loader (
    .clk(clk),
    .resetn(resetn),
    .otp_valid(otp_valid),
    .load_pulse(load_pulse),
    .load_done(load_done)
  );

  assign defaults_loaded = load_done;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign wr_mon1_w = reg_wr && addr_is(reg_addr, `SML_OFS_MON1);
  assign wr_mon2_w = reg_wr && addr_is(reg_addr, `SML_OFS_MON2);
  assign wr_conv_w = reg_wr && addr_is(reg_addr, `SML_OFS_CONV);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  // The one OTP load comes before any write; a write in the load cycle loses,
  // since software should not touch the bank before the defaults settle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon1_r <= `SML_RESET_VAL;
    end else if (load_pulse) begin
      mon1_r <= otp_mon1_default;
    end else if (wr_mon1_w) begin
      mon1_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mon2_r <= `SML_RESET_VAL;
    end else if (load_pulse) begin
      mon2_r <= otp_mon2_default;
    end else if (wr_mon2_w) begin
      mon2_r <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      conv_r <= `SML_RESET_VAL;
    end else if (load_pulse) begin
      conv_r <= otp_conv_default;
    end else if (wr_conv_w) begin
      conv_r <= reg_wdata;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      if (addr_is(reg_addr, `SML_OFS_MON1)) begin
        rdata_nxt = mon1_r;
      end else if (addr_is(reg_addr, `SML_OFS_MON2)) begin
        rdata_nxt = mon2_r;
      end else if (addr_is(reg_addr, `SML_OFS_CONV)) begin
        rdata_nxt = conv_r;
      end else begin
        rdata_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= 8'h00;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  // Handshake flag: tells the host port this bank owns the address
  assign reg_hit = addr_is(reg_addr, `SML_OFS_MON1) || addr_is(reg_addr, `SML_OFS_MON2)
    || addr_is(reg_addr, `SML_OFS_CONV);

  // ----------------------------------------
  // Monitor input decode
  // ----------------------------------------
  sml_monitor_decode u_mon1 (
    .tolerance_code(mon1_r[`SML_MON1_TOL_HI:`SML_MON1_TOL_LO]),
    .level_code(mon1_r[`SML_MON1_LVL_HI:`SML_MON1_LVL_LO]),
    .tolerance_pct(tol1_w),
    .level_mv(lvl1_w),
    .divider_on(div1_w)
  );

  sml_monitor_decode u_mon2 (
    .tolerance_code(mon2_r[`SML_MON2_TOL_HI:`SML_MON2_TOL_LO]),
    .level_code(mon2_r[`SML_MON2_LVL_HI:`SML_MON2_LVL_LO]),
    .tolerance_pct(tol2_w),
    .level_mv(lvl2_w),
    .divider_on(div2_w)
  );

  // ----------------------------------------
  // Registered comparator selections
  // ----------------------------------------
  // Outputs are flopped so the analog side never sees decode glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_input_tolerance <= 4'h0;
      first_input_level <= 12'h000;
      first_input_divider_on <= 1'b0;
    end else begin
      first_input_tolerance <= tol1_w;
      first_input_level <= lvl1_w;
      first_input_divider_on <= div1_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      second_input_tolerance <= 4'h0;
      second_input_level <= 12'h000;
      second_input_divider_on <= 1'b0;
    end else begin
      second_input_tolerance <= tol2_w;
      second_input_level <= lvl2_w;
      second_input_divider_on <= div2_w;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_supply_tolerance <= 4'h0;
    end else begin
      analog_supply_tolerance <= supply_tol_pct(mon2_r[`SML_ANA_TOL_HI:`SML_ANA_TOL_LO]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      analog_supply_level <= 12'h000;
    end else begin
      analog_supply_level <= supply_level(mon2_r[`SML_ANA_LVL_BIT]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boost_tolerance <= 4'h0;
    end else begin
      boost_tolerance <= boost_tol_pct(conv_r[`SML_BOOST_TOL_HI:`SML_BOOST_TOL_LO]);
    end
  end

  // No decoded meaning is defined for this field, so the raw code is passed on
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      boost_level_code <= 2'h0;
    end else begin
      boost_level_code <= conv_r[`SML_BOOST_LVL_HI:`SML_BOOST_LVL_LO];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      second_step_down_tolerance <= 7'h00;
    end else begin
      second_step_down_tolerance <= step_down_mv(conv_r[`SML_STEP1_TOL_HI:`SML_STEP1_TOL_LO]);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      first_step_down_tolerance <= 7'h00;
    end else begin
      first_step_down_tolerance <= step_down_mv(conv_r[`SML_STEP0_TOL_HI:`SML_STEP0_TOL_LO]);
    end
  end

  // ----------------------------------------
  // Window sides
  // ----------------------------------------
  // Lower limit always checked; upper only with the two-sided option
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      over_check_enable <= 1'b0;
    end else begin
      over_check_enable <= two_sided_check_select;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      under_check_enable <= 1'b0;
    end else begin
      under_check_enable <= 1'b1;
    end
  end

endmodule : sml_level_regs

// *** tb/sml_level_regs_checker.sv ***
// Purpose: Concurrent checks on the supply level register ports
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to sml_level_regs from tb_top
module sml_level_regs_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_hit,
  input wire logic [7:0] otp_conv_default,
  input wire logic two_sided_check_select,
  input wire logic defaults_loaded,
  input wire logic [11:0] first_input_level,
  input wire logic first_input_divider_on,
  input wire logic [11:0] analog_supply_level,
  input wire logic [1:0] boost_level_code,
  input wire logic [6:0] first_step_down_tolerance,
  input wire logic over_check_enable,
  input wire logic under_check_enable
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_hit;
    reg_hit == (reg_addr inside {8'h14, 8'h15, 8'h16});
  endproperty
  a_hit: assert property (p_hit) else $error("address hit wrong");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'h14, 8'h15, 8'h16}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Reset value 0 is below every level, so the reset state passes too
  property p_div;
    first_input_divider_on == (first_input_level > 12'd650);
  endproperty
  a_div: assert property (p_div) else $error("divider and level disagree");
  property p_step;
    reg_wr && defaults_loaded && reg_addr == 8'h16 |=>
      ##1 first_step_down_tolerance == 7'd30 + 7'd20 * $past(reg_wdata[1:0], 2);
  endproperty
  a_step: assert property (p_step) else $error("step-down tolerance wrong");
  property p_ana;
    reg_wr && defaults_loaded && reg_addr == 8'h15 |=>
      ##1 analog_supply_level == ($past(reg_wdata[5], 2) ? 12'd500 : 12'd330);
  endproperty
  a_ana: assert property (p_ana) else $error("analog level wrong");
  property p_chk;
    resetn |=> over_check_enable == $past(two_sided_check_select) && under_check_enable;
  endproperty
  a_chk: assert property (p_chk) else $error("check enables wrong");
  property p_load;
    $rose(defaults_loaded) |-> ##1 boost_level_code == $past(otp_conv_default[5:4], 2);
  endproperty
  a_load: assert property (p_load) else $error("default not loaded");
  property p_rd;
    reg_rd && reg_addr == 8'h16 |=> reg_rdata[5:4] == boost_level_code;
  endproperty
  a_rd: assert property (p_rd) else $error("boost field readback wrong");
  c_load: cover property ($rose(defaults_loaded));
  c_wr: cover property (reg_wr && defaults_loaded && reg_addr == 8'h16);
  c_unmapped: cover property (reg_rd && !reg_hit);
endmodule : sml_level_regs_checker

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for the supply level registers
// Assumes: Decoded outputs follow a write two edges later
// Notes: Exhaustive data sweep, then seeded random traffic
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 1'b0, reg_rd = 1'b0, reg_hit, otp_valid = 1'b1, two_sided_check_select = 1'b0;
  logic [7:0] otp_mon1_default, otp_mon2_default, otp_conv_default;
  logic defaults_loaded, first_input_divider_on, second_input_divider_on, over_check_enable, under_check_enable;
  logic [3:0] first_input_tolerance, second_input_tolerance, analog_supply_tolerance, boost_tolerance;
  logic [11:0] first_input_level, second_input_level, analog_supply_level;
  logic [1:0] boost_level_code;
  logic [6:0] first_step_down_tolerance, second_step_down_tolerance;
  logic [7:0] m [3];
  int seed = 6662, err_count = 0, checks_done = 0;
  // Names match the design ports one for one
  sml_level_regs sml_level_regs_i (.*);
  always #4 clk = ~clk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [11:0] lvl(input logic [2:0] c);
    logic [11:0] t [8] = '{650, 800, 1000, 1100, 1200, 1300, 1800, 1800};
    return t[c];
  endfunction : lvl
  task automatic chk(input string n, input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", n, exp, got);
    end
  endtask : chk
  // Strobes stay up between calls so no signal is driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    if (a inside {[8'h14:8'h16]}) m[a - 8'h14] = d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    chk("rdata", reg_rdata, e);
  endtask : rd
  task automatic dec;
    reg_wr = 1'b0;
    @(posedge clk) #1;
    chk("tol1", first_input_tolerance, m[0][4:3] == 3 ? 6 : m[0][4:3] + 2);
    chk("lvl1", first_input_level, lvl(m[0][2:0]));
    chk("div1", first_input_divider_on, m[0][2:0] != 0);
    chk("tola", analog_supply_tolerance, m[1][7] ? 10 : m[1][7:6] + 4);
    chk("lvla", analog_supply_level, m[1][5] ? 500 : 330);
    chk("tol2", second_input_tolerance, m[1][4:3] == 3 ? 6 : m[1][4:3] + 2);
    chk("lvl2", second_input_level, lvl(m[1][2:0]));
    chk("div2", second_input_divider_on, m[1][2:0] != 0);
    chk("tolb", boost_tolerance, 2 * m[2][7:6] + 2);
    chk("tols1", second_step_down_tolerance, 20 * m[2][3:2] + 30);
    chk("tols0", first_step_down_tolerance, 20 * m[2][1:0] + 30);
    chk("blvl", boost_level_code, m[2][5:4]);
    chk("over", over_check_enable, two_sided_check_select);
    chk("under", under_check_enable, 1'b1);
    for (int i = 0; i < 3; i++) rd(8'(8'h14 + i), m[i]);
    rd(8'h17, 8'h00);
    reg_rd = 1'b0;
  endtask : dec
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : conclude
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    otp_mon1_default = 8'($random(seed));
    otp_mon2_default = 8'($random(seed));
    otp_conv_default = 8'($random(seed));
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    // A write in the load cycle must lose to the default
    wr(8'h14, ~otp_mon1_default);
    m = '{otp_mon1_default, otp_mon2_default, otp_conv_default};
    dec;
    chk("loaded", defaults_loaded, 1'b1);
    $display("load test done");
    for (int v = 0; v < 256; v++) begin
      for (int a = 0; a < 3; a++) begin
        two_sided_check_select = v[a];
        wr(8'(8'h14 + a), 8'(v));
        dec;
      end
    end
    $display("sweep test done");
    for (int i = 0; i < 60; i++) begin
      otp_conv_default = 8'($random(seed));
      two_sided_check_select = 1'($random(seed));
      wr(8'(8'h13 + {$random(seed)} % 5), 8'($random(seed)));
      wr(8'(8'h13 + {$random(seed)} % 5), 8'($random(seed)));
      dec;
    end
    $display("random test done");
    otp_valid = 1'b0;
    resetn = 1'b0;
    @(posedge clk) #1 resetn = 1'b1;
    for (int i = 0; i < 3; i++) rd(8'(8'h14 + i), 8'h00);
    reg_rd = 1'b0;
    chk("loaded", defaults_loaded, 1'b0);
    otp_valid = 1'b1;
    m = '{otp_mon1_default, otp_mon2_default, otp_conv_default};
    @(posedge clk) #1;
    dec;
    $display("second reset test done");
    conclude;
  end
endmodule : tb_top

bind sml_level_regs sml_level_regs_checker sml_level_regs_checker_i (.*);
